// ==== rtl/pcs_core.sv ====
// Program counter, two-level return stack and indirect data addressing core
// Functional notes
// [R1] Counter holds next address and increments each cycle unless loaded; a PCS_OP_HOLD command keeps it unchanged.
// [R2] Unconditional jump loads counter bits 8:0 from the instruction field.
// [R3] Page select bit 5 of status supplies counter bit 9 on loads.
// [R4] Counter low byte is a data-space register reading and writing bits 7:0.
// [R5] Call or low-byte write loads bits 7:0 and clears bit 8.
// [R6] Reset sets counter to last location; it then wraps to 00h.
// [R7] Reset clears the page select bit, selecting page 0.
// [R8] Two-level, 12-bit hardware return stack, no software push or pop.
// [R9] Call copies level 1 into level 2, then counter plus one into level 1.
// [R10] Beyond two nested calls only the newest two addresses are kept.
// [R11] Return loads counter from level 1, copies level 2 into level 1.
// [R12] Return also loads the working register with the literal.
// [R13] No overflow flags; repeated returns keep returning level 2.
// [R14] Indirect port access goes to the register the pointer selects.
// [R15] Indirect read with pointer zero returns 00h.
// [R16] Indirect write with pointer zero changes no register.
// [R17] Pointer bits 4:0 select address 00h to 1Fh within a bank.
// [R18] 14-pin variant: bits 6:5 pick one of four banks, bit 7 reads one.
// [R19] 8-pin variant: bit 5 picks one of two banks, bits 7:6 read ones.
// [R20] Page select set picks page 1 (200h-3FFh), clear picks page 0.
// [R21] Counter is ten bits over two 512-word pages, reset to all ones.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_core
	import pcs_pkg::*;
#(
	parameter int  PC_W     = 10,
	parameter int  STACK_W  = 12,
	parameter bit  FOUR_BANK = 1'b1
) (
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire pcs_cmd_t        cmd,
	input  wire logic [7:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [7:0]      reg_rdata,
	input  wire logic [7:0]      mem_rdata,
	output pcs_mem_t             mem_req,
	output logic      [PC_W-1:0] prog_addr,
	output logic      [7:0]      work_load,
	output logic                 work_load_en,
	output logic                 page_select_bit
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [PC_W-1:0]    pc;
	logic [STACK_W-1:0] stack_lvl [`PCS_STACK_DEPTH];
	logic [STACK_W-1:0] push_src  [`PCS_STACK_DEPTH];
	logic [STACK_W-1:0] pop_src   [`PCS_STACK_DEPTH];
	logic [STACK_W-1:0] stack_l1;
	logic [STACK_W-1:0] stack_l2;
	logic [7:0]         status;
	logic [7:0]         indirect_pointer;
	logic [PC_W-1:0]    next_pc;
	logic [7:0]         next_rdata;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire        hit_ind    = (reg_addr == `PCS_OFF_INDIRECT_PORT);
	wire        hit_pcl    = (reg_addr == `PCS_OFF_COUNTER_LOW);
	wire        hit_status = (reg_addr == `PCS_OFF_STATUS);
	wire        hit_ptr    = (reg_addr == `PCS_OFF_POINTER);
	wire        pcl_write  = reg_wr && hit_pcl;
	wire        ptr_zero   = (indirect_pointer[4:0] == 5'h00) &&
	                         (indirect_pointer[6:5] == 2'b00 || !FOUR_BANK);
	wire [1:0]  bank       = FOUR_BANK ? indirect_pointer[6:5] // R18
	                                   : {1'b0, indirect_pointer[5]}; // R19
	wire [7:0]  ptr_view   = FOUR_BANK ? {1'b1, indirect_pointer[6:0]} // R18
	                                   : {2'b11, indirect_pointer[5:0]}; // R19
	wire        page       = status[`PCS_PAGE_BIT]; // R20
	wire [PC_W-1:0] pc_inc = pc + 1'b1; // R1 R6

	// Decoder operations and indirect strobes
	// A low-byte write overrides the command, so no stack action then
	wire        do_step    = (cmd.op == PCS_OP_STEP) && !pcl_write; // R1
	wire        do_jump    = (cmd.op == PCS_OP_JUMP) && !pcl_write; // R2
	wire        do_call    = (cmd.op == PCS_OP_CALL) && !pcl_write; // R9
	wire        do_return  = (cmd.op == PCS_OP_RETURN) && !pcl_write; // R11
	wire        ind_wr     = reg_wr && hit_ind && !ptr_zero; // R16
	wire        ind_rd     = reg_rd && hit_ind && !ptr_zero; // R15
	wire [6:0]  ind_addr   = {bank, indirect_pointer[4:0]}; // R17

	// Load values; bit 9 always comes from the page select bit
	// Bit 8 is cleared on calls and computed jumps, so they stay low in a page
	wire [PC_W-1:0] jump_pc = {page, cmd.target}; // R2 R3
	wire [PC_W-1:0] call_pc = {page, 1'b0, cmd.target[7:0]}; // R3 R5
	wire [PC_W-1:0] pcl_pc  = {page, 1'b0, reg_wdata}; // R3 R4 R5

	// Indirect access forwarded to the register file, the port stores nothing
	assign mem_req = '{wr: ind_wr, rd: ind_rd, addr: ind_addr, wdata: reg_wdata}; // R14

	assign prog_addr       = pc;
	assign page_select_bit = page;

	// ----------------------------------------------------------------
	// Next counter selection
	// ----------------------------------------------------------------
	// A low-byte write wins over the decoder command in the same cycle
	always_comb begin
		next_pc = pc_inc; // R1
		if (pcl_write) begin
			next_pc = pcl_pc; // R3 R4 R5
		end else begin
			unique case (cmd.op)
				PCS_OP_STEP:   next_pc = pc_inc;
				PCS_OP_JUMP:   next_pc = jump_pc; // R2 R3
				PCS_OP_CALL:   next_pc = call_pc; // R3 R5
				PCS_OP_RETURN: next_pc = stack_l1[PC_W-1:0]; // R11
				PCS_OP_HOLD:   next_pc = pc;
				default:       next_pc = pc_inc;
			endcase
		end
	end

	// Read data mux, answered one cycle after the strobe
	// Unmapped addresses fall through to zero
	always_comb begin
		next_rdata = 8'h00;
		if (hit_ind) begin
			next_rdata = ptr_zero ? `PCS_IND_ZERO_READ : mem_rdata; // R14 R15
		end else if (hit_pcl) begin
			next_rdata = pc[7:0]; // R4
		end else if (hit_status) begin
			next_rdata = status;
		end else if (hit_ptr) begin
			next_rdata = ptr_view;
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= `PCS_PC_RESET; // R6 R21
		end else begin
			pc <= next_pc;
		end
	end

	// ----------------------------------------------------------------
	// Return stack, no depth tracking or flags
	// ----------------------------------------------------------------
	// A call shifts every level down and drops the oldest; a return shifts
	// every level up while the bottom level keeps its value and repeats
	for (genvar g = 0; g < `PCS_STACK_DEPTH; g++) begin : g_level
		if (g == 0) begin : g_top
			assign push_src[g] = STACK_W'(pc_inc); // R9
		end else begin : g_lower
			assign push_src[g] = stack_lvl[g-1]; // R9 R10
		end
		if (g == `PCS_STACK_DEPTH - 1) begin : g_bottom
			assign pop_src[g] = stack_lvl[g]; // R13
		end else begin : g_upper
			assign pop_src[g] = stack_lvl[g+1]; // R11
		end

		// One level of the stack
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				stack_lvl[g] <= `PCS_STACK_RESET;
			end else if (do_call) begin
				stack_lvl[g] <= push_src[g]; // R8 R9
			end else if (do_return) begin
				stack_lvl[g] <= pop_src[g]; // R11
			end
		end
	end

	// Named views of the two levels
	assign stack_l1 = stack_lvl[0];
	assign stack_l2 = stack_lvl[1];

	// ----------------------------------------------------------------
	// Status page bit and pointer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status           <= `PCS_STATUS_RESET; // R7
			indirect_pointer <= `PCS_PTR_RESET;
		end else begin
			if (reg_wr && hit_status) begin
				status <= reg_wdata & `PCS_STATUS_WMASK; // R20
			end
			if (reg_wr && hit_ptr) begin
				indirect_pointer <= reg_wdata;
			end
		end
	end

	// Read data and working register load
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata    <= 8'h00;
			work_load    <= 8'h00;
			work_load_en <= 1'b0;
		end else begin
			reg_rdata    <= reg_rd ? next_rdata : 8'h00;
			work_load_en <= do_return; // R12
			work_load    <= cmd.literal; // R12
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_STEP: assert property (@(posedge clk) disable iff (!rst_b) // R1
		(cmd.op == PCS_OP_STEP && !pcl_write) |=> pc == $past(pc_inc))
		else $error("counter did not step");
	AST_JUMP: assert property (@(posedge clk) disable iff (!rst_b) // R2
		(cmd.op == PCS_OP_JUMP && !pcl_write) |=> pc[8:0] == $past(cmd.target))
		else $error("jump target wrong");
	AST_PAGE: assert property (@(posedge clk) disable iff (!rst_b) // R3
		(cmd.op inside {PCS_OP_JUMP, PCS_OP_CALL}) |=> pc[9] == $past(page))
		else $error("page bit not applied");
	AST_PCL_WR: assert property (@(posedge clk) disable iff (!rst_b) // R5
		pcl_write |=> pc[8:0] == {1'b0, $past(reg_wdata)})
		else $error("low byte write wrong");
	AST_PCL_RD: assert property (@(posedge clk) disable iff (!rst_b) // R4
		(reg_rd && hit_pcl) |=> reg_rdata == $past(pc[7:0]))
		else $error("low byte read wrong");
	AST_CALL: assert property (@(posedge clk) disable iff (!rst_b) // R9
		(cmd.op == PCS_OP_CALL && !pcl_write) |=>
		stack_l2 == $past(stack_l1) && stack_l1 == STACK_W'($past(pc) + 1'b1))
		else $error("call push wrong");
	AST_RET: assert property (@(posedge clk) disable iff (!rst_b) // R11
		(cmd.op == PCS_OP_RETURN && !pcl_write) |=>
		pc == $past(stack_l1[PC_W-1:0]) && stack_l1 == $past(stack_l2) &&
		stack_l2 == $past(stack_l2))
		else $error("return pop wrong");
	AST_LIT: assert property (@(posedge clk) disable iff (!rst_b) // R12
		(cmd.op == PCS_OP_RETURN && !pcl_write) |=>
		work_load_en && work_load == $past(cmd.literal))
		else $error("literal not loaded");
	AST_IND0: assert property (@(posedge clk) disable iff (!rst_b) // R15
		(reg_rd && hit_ind && ptr_zero) |=> reg_rdata == 8'h00)
		else $error("pointer zero read not zero");
	AST_INDW: assert property (@(posedge clk) disable iff (!rst_b) // R16
		ptr_zero |-> !mem_req.wr)
		else $error("write through pointer zero");
	AST_PTR: assert property (@(posedge clk) disable iff (!rst_b) // R17
		mem_req.addr[4:0] == indirect_pointer[4:0])
		else $error("indirect address wrong");

	// ----------------------------------------------------------------
	// Checks on reset, wrap, counter hold and loads, stack and working register
	// ----------------------------------------------------------------
	// Counter sits at the reset vector at the release edge
	AST_RST_VEC: assert property (@(posedge clk) // R6
		$rose(rst_b) |-> pc == `PCS_PC_RESET)
		else $error("counter not at reset vector");
	// Page 0 is preselected when reset is let go
	AST_RST_PAGE: assert property (@(posedge clk) // R7
		$rose(rst_b) |-> !page)
		else $error("page select not cleared by reset");
	// The instruction at the reset vector is followed by location zero
	AST_WRAP: assert property (@(posedge clk) disable iff (!rst_b) // R6
		(do_step && pc == `PCS_PC_RESET) |=> pc == '0)
		else $error("counter did not wrap to zero");
	// A stalled decoder leaves the counter where it is
	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // R1
		(cmd.op == PCS_OP_HOLD && !pcl_write) |=> $stable(pc))
		else $error("counter moved while held");
	// Calls reach only the low half of a page
	AST_CALL_LOW: assert property (@(posedge clk) disable iff (!rst_b) // R5
		do_call |=> !pc[8] && pc[7:0] == $past(cmd.target[7:0]))
		else $error("call did not clear bit 8");
	// A computed jump takes precedence and leaves the stack alone
	AST_PCL_STACK: assert property (@(posedge clk) disable iff (!rst_b) // R5
		pcl_write |=> $stable(stack_l1) && $stable(stack_l2))
		else $error("stack moved on low byte write");
	// Computed jumps also take their page from the status bit
	AST_PCL_PAGE: assert property (@(posedge clk) disable iff (!rst_b) // R3
		pcl_write |=> pc[PC_W-1] == $past(page))
		else $error("computed jump page wrong");
	// After any return both levels hold the same address
	AST_RET_FILL: assert property (@(posedge clk) disable iff (!rst_b) // R13
		do_return |=> stack_l1 == stack_l2)
		else $error("stack levels differ after return");
	// The working register is only loaded by a return
	AST_LIT_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // R12
		!do_return |=> !work_load_en)
		else $error("working register load without return");

	// ----------------------------------------------------------------
	// Checks on the register port and indirect path
	// ----------------------------------------------------------------
	// Read data are zero outside the cycle after a read strobe
	AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b) // R4
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	// Unmapped addresses read as zero
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_b) // R4
		(reg_rd && !hit_ind && !hit_pcl && !hit_status && !hit_ptr) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// Indirect reads return what the register file holds
	AST_IND_RD: assert property (@(posedge clk) disable iff (!rst_b) // R14
		(reg_rd && hit_ind && !ptr_zero) |=> reg_rdata == $past(mem_rdata))
		else $error("indirect read data wrong");
	// Indirect writes reach the register file unchanged
	AST_IND_WR: assert property (@(posedge clk) disable iff (!rst_b) // R14
		(reg_wr && hit_ind && !ptr_zero) |-> mem_req.wr && mem_req.wdata == reg_wdata)
		else $error("indirect write not forwarded");
	// The port addressing itself touches nothing
	AST_IND0_QUIET: assert property (@(posedge clk) disable iff (!rst_b) // R16
		(hit_ind && ptr_zero) |-> !mem_req.wr && !mem_req.rd)
		else $error("indirect access through pointer zero");
	// Pointer writes are kept whole
	AST_PTR_WR: assert property (@(posedge clk) disable iff (!rst_b) // R17
		(reg_wr && hit_ptr) |=> indirect_pointer == $past(reg_wdata))
		else $error("pointer write lost");
	// Unimplemented top pointer bit reads as one in both variants
	AST_PTR_TOP: assert property (@(posedge clk) disable iff (!rst_b) // R18
		(reg_rd && hit_ptr) |=> reg_rdata[7])
		else $error("pointer bit 7 not one");
	// The two-bank variant also reads bit 6 as one
	AST_PTR_PAIR: assert property (@(posedge clk) disable iff (!rst_b) // R19
		(reg_rd && hit_ptr && !FOUR_BANK) |=> reg_rdata[7:6] == 2'b11)
		else $error("pointer bits 7:6 not ones");
	// Four banks come from pointer bits 6:5
	AST_BANK4: assert property (@(posedge clk) disable iff (!rst_b) // R18
		FOUR_BANK |-> mem_req.addr[6:5] == indirect_pointer[6:5])
		else $error("four-bank select wrong");
	// Two banks come from pointer bit 5 alone
	AST_BANK2: assert property (@(posedge clk) disable iff (!rst_b) // R19
		!FOUR_BANK |-> !mem_req.addr[6] && mem_req.addr[5] == indirect_pointer[5])
		else $error("two-bank select wrong");
	// Only the page select bit of status is stored
	AST_STATUS: assert property (@(posedge clk) disable iff (!rst_b) // R20
		(reg_wr && hit_status) |=>
		page == $past(reg_wdata[`PCS_PAGE_BIT]) && (status & ~`PCS_STATUS_WMASK) == 8'h00)
		else $error("status write wrong");
	// The page stays put until software writes status
	AST_PAGE_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // R7
		!(reg_wr && hit_status) |=> $stable(page))
		else $error("page select changed without a write");

endmodule

// ==== rtl/pcs_defines.svh ====
// Constants for the program counter, return stack and indirect addressing core
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the software port
// ----------------------------------------------------------------
`define PCS_OFF_INDIRECT_PORT 8'h00
`define PCS_OFF_COUNTER_LOW   8'h02
`define PCS_OFF_STATUS        8'h03
`define PCS_OFF_POINTER       8'h04

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PCS_PAGE_BIT          5
`define PCS_PC_RESET          10'h3FF
`define PCS_PTR_RESET         8'h00
`define PCS_STATUS_RESET      8'h00
`define PCS_STACK_RESET       12'h000
`define PCS_IND_ZERO_READ     8'h00
`define PCS_STATUS_WMASK      8'h20
`define PCS_STACK_DEPTH       2

`endif

// ==== rtl/pcs_pkg.sv ====
// Types for the program counter, return stack and indirect addressing core
package pcs_pkg;

	// Program flow operation requested by the instruction decoder
	typedef enum logic [2:0] {
		PCS_OP_STEP,
		PCS_OP_JUMP,
		PCS_OP_CALL,
		PCS_OP_RETURN,
		PCS_OP_HOLD
	} pcs_op_t;

	// One decoder command with its operands
	typedef struct packed {
		pcs_op_t    op;
		logic [8:0] target;
		logic [7:0] literal;
	} pcs_cmd_t;

	// Data register file access produced by the indirect path
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} pcs_mem_t;

endpackage

// ==== testbench/pcs_regfile_model.sv ====
// Behavioural data register file on the far side of the indirect path
`timescale 1ns/1ps

module pcs_regfile_model
	import pcs_pkg::*;
(
	input  wire logic     clk,
	input  wire pcs_mem_t mem_req,
	output logic [7:0]    mem_rdata
);
	logic [7:0] mem [128];

	// ------------------------------------------------
	// Storage
	// ------------------------------------------------
	// Known pattern so a stray write shows up
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'hA5 ^ 8'(i);
		end
	end

	// Write whatever the indirect path selects
	always @(posedge clk) begin
		if (mem_req.wr) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
	end

	// Unselected reads show inverted data, never a stale match
	assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~mem[mem_req.addr];
endmodule

// ==== testbench/pc_stack_indirect_addressing_test.sv ====
// Self-checking bench for the counter, return stack and indirect core
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pc_stack_indirect_addressing_test
	import pcs_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	pcs_cmd_t   cmd = '{PCS_OP_HOLD, 9'h000, 8'h00};
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata, rdata8, mem_rdata, work_load, rd_val;
	pcs_mem_t   mem_req;
	logic [9:0] prog_addr;
	logic       work_load_en, page_select_bit;
	int         n_errors = 0;
	int         n_checks = 0;

	// ------------------------------------------------
	// Clock, designs and register file
	// ------------------------------------------------
	always #5 clk = ~clk;

	pcs_core #(.FOUR_BANK(1'b1)) dut (.clk(clk), .rst_b(rst_b), .cmd(cmd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .mem_req(mem_req),
		.prog_addr(prog_addr), .work_load(work_load), .work_load_en(work_load_en),
		.page_select_bit(page_select_bit));
	// Two-bank variant, only its pointer read-back is watched
	pcs_core #(.FOUR_BANK(1'b0)) dut8 (.clk(clk), .rst_b(rst_b), .cmd(cmd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdata8), .mem_rdata(8'h00), .mem_req(), .prog_addr(),
		.work_load(), .work_load_en(), .page_select_bit());
	pcs_regfile_model mdl (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	// ------------------------------------------------
	// Compare, access and closing tasks
	// ------------------------------------------------
	task automatic chk_d(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_pc(input logic [9:0] exp);
		n_checks++;
		if (prog_addr !== exp) begin
			n_errors++;
			$display("unexpected at %0t: counter %h, wanted %h", $time, prog_addr, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask
	task automatic op(input pcs_op_t o, input logic [8:0] t, input logic [7:0] l);
		@(posedge clk);
		cmd <= '{o, t, l};
		@(posedge clk);
		cmd.op <= PCS_OP_HOLD;
		#1;
	endtask
	task automatic stop_test;
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#20000;
		n_errors++;
		stop_test;
	end

	// ------------------------------------------------
	// Test sequence
	// ------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		chk_pc(10'h3FF);
		rst_b <= 1'b1;
		op(PCS_OP_STEP, 9'h000, 8'h00);
		chk_pc(10'h000);
		op(PCS_OP_STEP, 9'h000, 8'h00);
		chk_pc(10'h001);
		op(PCS_OP_JUMP, 9'h1AB, 8'h00);
		chk_pc(10'h1AB);
		wr(`PCS_OFF_STATUS, 8'hFF);
		rd(`PCS_OFF_STATUS);
		chk_d(rd_val, 8'h20);
		chk_d({7'h00, page_select_bit}, 8'h01);
		op(PCS_OP_JUMP, 9'h005, 8'h00);
		chk_pc(10'h205);
		op(PCS_OP_CALL, 9'h140, 8'h00);
		chk_pc(10'h240);
		op(PCS_OP_CALL, 9'h080, 8'h00);
		chk_pc(10'h280);
		op(PCS_OP_CALL, 9'h010, 8'h00);
		chk_pc(10'h210);
		op(PCS_OP_RETURN, 9'h000, 8'h11);
		chk_pc(10'h281);
		chk_d(work_load, 8'h11);
		chk_d({7'h00, work_load_en}, 8'h01);
		op(PCS_OP_RETURN, 9'h000, 8'h22);
		chk_pc(10'h241);
		op(PCS_OP_RETURN, 9'h000, 8'h33);
		chk_pc(10'h241);
		wr(`PCS_OFF_COUNTER_LOW, 8'hC7);
		chk_pc(10'h2C7);
		rd(`PCS_OFF_COUNTER_LOW);
		chk_d(rd_val, 8'hC7);
		wr(`PCS_OFF_POINTER, 8'h27);
		rd(`PCS_OFF_POINTER);
		chk_d(rd_val, 8'hA7);
		chk_d(rdata8, 8'hE7);
		wr(`PCS_OFF_INDIRECT_PORT, 8'h5C);
		chk_d(mdl.mem[7'h27], 8'h5C);
		rd(`PCS_OFF_INDIRECT_PORT);
		chk_d(rd_val, 8'h5C);
		wr(`PCS_OFF_POINTER, 8'h00);
		wr(`PCS_OFF_INDIRECT_PORT, 8'h99);
		chk_d(mdl.mem[7'h00], 8'hA5);
		rd(`PCS_OFF_INDIRECT_PORT);
		chk_d(rd_val, 8'h00);
		rd(8'h01);
		chk_d(rd_val, 8'h00);
		// Second reset with page 1 selected
		@(posedge clk);
		rst_b <= 1'b0;
		#1;
		chk_pc(10'h3FF);
		chk_d({7'h00, page_select_bit}, 8'h00);
		// Release again: wrap to zero, jumps land in page 0
		@(posedge clk);
		rst_b <= 1'b1;
		op(PCS_OP_STEP, 9'h000, 8'h00);
		chk_pc(10'h000);
		op(PCS_OP_JUMP, 9'h1AB, 8'h00);
		chk_pc(10'h1AB);
		stop_test;
	end
endmodule
